// File: src/cpu_core_pkg.sv
// cpu_core_pkg: types shared by the register set and its helpers
// assumes: nothing beyond the standard language
package cpu_core_pkg;

    typedef enum logic [4:0] {
        VIEW_FULL = 5'h01,
        VIEW_EXT = 5'h02,
        VIEW_WORD = 5'h04,
        VIEW_HIGH_BYTE = 5'h08,
        VIEW_LOW_BYTE = 5'h10
    } view_e;

    typedef enum logic [2:0] {
        SIZE_BYTE = 3'h1,
        SIZE_WORD = 3'h2,
        SIZE_LONG = 3'h4
    } size_e;

    typedef enum logic [4:0] {
        OP_ADD = 5'h01,
        OP_SUB = 5'h02,
        OP_NEG = 5'h04,
        OP_LOGIC = 5'h08,
        OP_SHIFT = 5'h10
    } op_e;

    typedef enum logic [4:0] {
        CTL_NONE = 5'h01,
        CTL_LOAD = 5'h02,
        CTL_AND = 5'h04,
        CTL_OR = 5'h08,
        CTL_XOR = 5'h10
    } ctl_op_e;

    typedef enum logic [5:0] {
        TGT_FLAGS = 6'h01,
        TGT_EXT = 6'h02,
        TGT_VEC = 6'h04,
        TGT_SHB = 6'h08,
        TGT_MACH = 6'h10,
        TGT_MACL = 6'h20
    } ctl_tgt_e;

    typedef enum logic [3:0] {
        COND_ALWAYS = 4'h0, COND_NEVER = 4'h1, COND_HI = 4'h2, COND_LS = 4'h3,
        COND_CC = 4'h4, COND_CS = 4'h5, COND_NE = 4'h6, COND_EQ = 4'h7,
        COND_VC = 4'h8, COND_VS = 4'h9, COND_PL = 4'hA, COND_MI = 4'hB,
        COND_GE = 4'hC, COND_LT = 4'hD, COND_GT = 4'hE, COND_LE = 4'hF
    } cond_e;

    typedef struct packed {
        logic [2:0] idx;
        view_e view;
    } gpr_sel_s;

    typedef struct packed {
        op_e op;
        size_e size;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] r;
        logic shift_c;
    } alu_s;

endpackage : cpu_core_pkg

// File: src/cpu_core_regs.svh
// cpu_core_regs.svh: bit positions, reset values and masks of the cpu register set
// assumes: included by bare name from every design file that needs it
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH

// ==========================================================================
// condition flags bit positions
`define FLG_I 7
`define FLG_U6 6
`define FLG_H 5
`define FLG_U 4
`define FLG_N 3
`define FLG_Z 2
`define FLG_V 1
`define FLG_C 0
`define FLG_RESET 8'h80

// ==========================================================================
// extended control, bases, accumulator
`define EXT_RESET 8'h7F
`define EXT_ONES 8'h78
`define VEC_MASK 32'hFFFFF000
`define VEC_RESET 32'h00000000
`define SHB_MASK 32'hFFFFFF00
`define SHB_RESET 32'hFFFFFF00
`define MACH_BITS 10
`define PC_RESET 32'h00000000
`define SP_INDEX 3'h7

// ==========================================================================
// operand widths and half-carry source bits
`define MSB_BYTE 7
`define MSB_WORD 15
`define MSB_LONG 31
`define HC_SRC_BYTE 3
`define HC_SRC_WORD 11
`define HC_SRC_LONG 27

`endif

// File: src/cpu_register_file_and_flags.sv
// cpu_register_file_and_flags: general registers, program counter and control registers
// assumes: driven by the core's execution and exception logic on i_clk
// Contract
// - eight alike 32-bit general registers
// - data access at 32, 16, 8 bits
// - upper and lower halves give sixteen words
// - lower half splits into two bytes
// - index read by operand size view
// - each register used independently per instruction
// - eighth register doubles as stack pointer
// - program counter; fetch ignores bit zero
// - instructions are whole 16-bit words
// - full control register set is held
// - mask bit resets set, forced on exception
// - user bits change only by control ops
// - half-carry from bit 3, 11, 27
// - negative flag takes result sign bit
// - zero flag marks zero result
// - overflow flag marks arithmetic overflow
// - carry from add, subtract, shift
// - carry is the bit accumulator
// - branches test negative, zero, overflow, carry
// - flags loadable, and, or, xor by immediate
// - reset clears trace, sets masks and short address base
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"
module cpu_register_file_and_flags #(
    parameter int GPR_COUNT = 8,
    parameter int WORDS_W = 4
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_gpr_wr,
    input wire cpu_core_pkg::gpr_sel_s i_gpr_wr_sel,
    input wire logic [31:0] i_gpr_wdata,
    input wire cpu_core_pkg::gpr_sel_s i_gpr_rd_sel,
    input wire logic [2:0] i_idx_reg,
    input wire cpu_core_pkg::size_e i_idx_size,
    input wire logic i_sp_wr,
    input wire logic [31:0] i_sp_wdata,
    input wire logic i_pc_load,
    input wire logic [31:0] i_pc_value,
    input wire logic i_pc_advance,
    input wire logic [WORDS_W-1:0] i_instr_words,
    input wire logic i_flag_upd,
    input wire cpu_core_pkg::alu_s i_alu,
    input wire logic i_bit_c_wr,
    input wire logic i_bit_c_value,
    input wire cpu_core_pkg::ctl_op_e i_ctl_op,
    input wire cpu_core_pkg::ctl_tgt_e i_ctl_tgt,
    input wire logic [31:0] i_ctl_wdata,
    input wire logic i_exception_start,
    input wire cpu_core_pkg::cond_e i_branch_cond,
    output logic [31:0] o_gpr_rd_data,
    output logic [31:0] o_idx_data,
    output logic [31:0] o_stack_pointer,
    output logic [31:0] o_pc,
    output logic [31:0] o_fetch_addr,
    output logic [7:0] o_condition_flags,
    output logic [7:0] o_extended_control,
    output logic [31:0] o_vector_base,
    output logic [31:0] o_short_address_base,
    output logic [63:0] o_multiply_accumulator,
    output logic o_branch_taken
);
    // ======================================================================
    // general registers
    logic [31:0] gpr_q [GPR_COUNT];
    logic slot_wr [GPR_COUNT];
    logic [3:0] slot_lanes [GPR_COUNT];
    logic [31:0] slot_data [GPR_COUNT];
    logic [3:0] wr_lanes;
    logic [31:0] wr_place;

    function automatic logic [31:0] view_read(input logic [31:0] q, input cpu_core_pkg::view_e v);
        case (v)
            cpu_core_pkg::VIEW_EXT: return {16'h0000, q[31:16]};
            cpu_core_pkg::VIEW_WORD: return {16'h0000, q[15:0]};
            cpu_core_pkg::VIEW_HIGH_BYTE: return {24'h000000, q[15:8]};
            cpu_core_pkg::VIEW_LOW_BYTE: return {24'h000000, q[7:0]};
            default: return q;
        endcase
    endfunction : view_read

    always_comb begin
        case (i_gpr_wr_sel.view)
            cpu_core_pkg::VIEW_EXT: begin
                wr_lanes = 4'hC;
                wr_place = {i_gpr_wdata[15:0], 16'h0000};
            end
            cpu_core_pkg::VIEW_WORD: begin
                wr_lanes = 4'h3;
                wr_place = {16'h0000, i_gpr_wdata[15:0]};
            end
            cpu_core_pkg::VIEW_HIGH_BYTE: begin
                wr_lanes = 4'h2;
                wr_place = {16'h0000, i_gpr_wdata[7:0], 8'h00};
            end
            cpu_core_pkg::VIEW_LOW_BYTE: begin
                wr_lanes = 4'h1;
                wr_place = {24'h000000, i_gpr_wdata[7:0]};
            end
            default: begin
                wr_lanes = 4'hF;
                wr_place = i_gpr_wdata;
            end
        endcase
        for (int g = 0; g < GPR_COUNT; g++) begin
            slot_wr[g] = i_gpr_wr && (i_gpr_wr_sel.idx == g[2:0]);
            slot_lanes[g] = wr_lanes;
            slot_data[g] = wr_place;
            if (i_sp_wr && (g[2:0] == `SP_INDEX)) begin
                slot_wr[g] = 1'b1;
                slot_lanes[g] = 4'hF;
                slot_data[g] = i_sp_wdata;
            end
        end
    end

    for (genvar g = 0; g < GPR_COUNT; g++) begin : gen_gpr
        gpr_slot #(.WIDTH(32), .LANES(4)) u_gpr_slot (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_wr_en(slot_wr[g]),
            .i_lane_en(slot_lanes[g]),
            .i_wdata(slot_data[g]),
            .o_q(gpr_q[g])
        );
    end

    logic [31:0] next_gpr_rd_data;
    logic [31:0] next_idx_data;
    logic [31:0] next_stack_pointer;

    always_comb begin
        next_gpr_rd_data = view_read(gpr_q[i_gpr_rd_sel.idx], i_gpr_rd_sel.view);
        case (i_idx_size)
            cpu_core_pkg::SIZE_BYTE: next_idx_data = {24'h000000, gpr_q[i_idx_reg][7:0]};
            cpu_core_pkg::SIZE_WORD: next_idx_data = {16'h0000, gpr_q[i_idx_reg][15:0]};
            default: next_idx_data = gpr_q[i_idx_reg];
        endcase
        next_stack_pointer = gpr_q[`SP_INDEX];
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_gpr_rd_data <= 32'h00000000;
            o_idx_data <= 32'h00000000;
            o_stack_pointer <= 32'h00000000;
        end else begin
            o_gpr_rd_data <= next_gpr_rd_data;
            o_idx_data <= next_idx_data;
            o_stack_pointer <= next_stack_pointer;
        end
    end

    // ======================================================================
    // program counter
    logic [31:0] next_pc;
    logic [31:0] next_fetch_addr;

    always_comb begin
        next_pc = o_pc;
        if (i_pc_load) begin
            next_pc = i_pc_value;
        end else if (i_pc_advance) begin
            next_pc = o_pc + {{(31-WORDS_W){1'b0}}, i_instr_words, 1'b0};
        end
        next_fetch_addr = {next_pc[31:1], 1'b0};
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pc <= `PC_RESET;
            o_fetch_addr <= `PC_RESET;
        end else begin
            o_pc <= next_pc;
            o_fetch_addr <= next_fetch_addr;
        end
    end

    // ======================================================================
    // condition flags and control registers
    logic fc_h, fc_n, fc_z, fc_v, fc_c, fc_c_load;
    logic flags_ctl;
    logic [7:0] next_flags;
    logic [7:0] next_ext;
    logic [31:0] next_vec;
    logic [31:0] next_shb;
    logic [63:0] next_mac;

    flag_calc u_flag_calc (
        .i_alu(i_alu),
        .o_h(fc_h),
        .o_n(fc_n),
        .o_z(fc_z),
        .o_v(fc_v),
        .o_c(fc_c),
        .o_c_load(fc_c_load)
    );

    function automatic logic [7:0] ctl_apply(input logic [7:0] q, input logic [7:0] imm,
                                             input cpu_core_pkg::ctl_op_e op);
        case (op)
            cpu_core_pkg::CTL_LOAD: return imm;
            cpu_core_pkg::CTL_AND: return q & imm;
            cpu_core_pkg::CTL_OR: return q | imm;
            cpu_core_pkg::CTL_XOR: return q ^ imm;
            default: return q;
        endcase
    endfunction : ctl_apply

    always_comb begin
        flags_ctl = (i_ctl_op != cpu_core_pkg::CTL_NONE) && (i_ctl_tgt == cpu_core_pkg::TGT_FLAGS);
        next_flags = o_condition_flags;
        if (i_flag_upd) begin
            next_flags[`FLG_H] = fc_h;
            next_flags[`FLG_N] = fc_n;
            next_flags[`FLG_Z] = fc_z;
            next_flags[`FLG_V] = fc_v;
            if (fc_c_load) begin
                next_flags[`FLG_C] = fc_c;
            end
        end
        if (i_bit_c_wr) begin
            next_flags[`FLG_C] = i_bit_c_value;
        end
        if (flags_ctl) begin
            next_flags = ctl_apply(o_condition_flags, i_ctl_wdata[7:0], i_ctl_op);
        end
        if (i_exception_start) begin
            next_flags[`FLG_I] = 1'b1;
        end
        next_ext = o_extended_control;
        if (i_ctl_tgt == cpu_core_pkg::TGT_EXT) begin
            next_ext = ctl_apply(o_extended_control, i_ctl_wdata[7:0], i_ctl_op) | `EXT_ONES;
        end
        next_vec = o_vector_base;
        next_shb = o_short_address_base;
        next_mac = o_multiply_accumulator;
        if (i_ctl_op == cpu_core_pkg::CTL_LOAD) begin
            case (i_ctl_tgt)
                cpu_core_pkg::TGT_VEC: next_vec = i_ctl_wdata & `VEC_MASK;
                cpu_core_pkg::TGT_SHB: next_shb = i_ctl_wdata & `SHB_MASK;
                cpu_core_pkg::TGT_MACH: next_mac[63:32] =
                    {{(32-`MACH_BITS){i_ctl_wdata[`MACH_BITS-1]}}, i_ctl_wdata[`MACH_BITS-1:0]};
                cpu_core_pkg::TGT_MACL: next_mac[31:0] = i_ctl_wdata;
                default: next_mac = o_multiply_accumulator;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_condition_flags <= `FLG_RESET;
            o_extended_control <= `EXT_RESET;
            o_vector_base <= `VEC_RESET;
            o_short_address_base <= `SHB_RESET;
            o_multiply_accumulator <= 64'h0000000000000000;
        end else begin
            o_condition_flags <= next_flags;
            o_extended_control <= next_ext;
            o_vector_base <= next_vec;
            o_short_address_base <= next_shb;
            o_multiply_accumulator <= next_mac;
        end
    end

    // ======================================================================
    // branch condition
    logic next_branch_taken;
    logic bn, bz, bv, bc;

    always_comb begin
        bn = o_condition_flags[`FLG_N];
        bz = o_condition_flags[`FLG_Z];
        bv = o_condition_flags[`FLG_V];
        bc = o_condition_flags[`FLG_C];
        case (i_branch_cond)
            cpu_core_pkg::COND_ALWAYS: next_branch_taken = 1'b1;
            cpu_core_pkg::COND_NEVER: next_branch_taken = 1'b0;
            cpu_core_pkg::COND_HI: next_branch_taken = !(bc | bz);
            cpu_core_pkg::COND_LS: next_branch_taken = bc | bz;
            cpu_core_pkg::COND_CC: next_branch_taken = !bc;
            cpu_core_pkg::COND_CS: next_branch_taken = bc;
            cpu_core_pkg::COND_NE: next_branch_taken = !bz;
            cpu_core_pkg::COND_EQ: next_branch_taken = bz;
            cpu_core_pkg::COND_VC: next_branch_taken = !bv;
            cpu_core_pkg::COND_VS: next_branch_taken = bv;
            cpu_core_pkg::COND_PL: next_branch_taken = !bn;
            cpu_core_pkg::COND_MI: next_branch_taken = bn;
            cpu_core_pkg::COND_GE: next_branch_taken = !(bn ^ bv);
            cpu_core_pkg::COND_LT: next_branch_taken = bn ^ bv;
            cpu_core_pkg::COND_GT: next_branch_taken = !(bz | (bn ^ bv));
            default: next_branch_taken = bz | (bn ^ bv);
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_branch_taken <= 1'b0;
        end else begin
            o_branch_taken <= next_branch_taken;
        end
    end

    // ======================================================================
    // checks
    property p_exc_mask;
        @(posedge i_clk) disable iff (!i_resetn)
        i_exception_start |=> o_condition_flags[`FLG_I];
    endproperty
    a_exc_mask: assert property (p_exc_mask)
        else $error("mask bit not set after exception start");

    property p_fetch_even;
        @(posedge i_clk) disable iff (!i_resetn)
        !o_fetch_addr[0] && (o_fetch_addr[31:1] == o_pc[31:1]);
    endproperty
    a_fetch_even: assert property (p_fetch_even)
        else $error("fetch address differs from counter or is odd");

    property p_pc_step;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_pc_advance && !i_pc_load) |=>
            (o_pc == $past(o_pc) + 2 * $past(i_instr_words));
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("counter did not step by whole words");

    property p_user_bits;
        @(posedge i_clk) disable iff (!i_resetn)
        !flags_ctl |=> $stable({o_condition_flags[`FLG_U6], o_condition_flags[`FLG_U]});
    endproperty
    a_user_bits: assert property (p_user_bits)
        else $error("user bits changed without control op");

    property p_neg_flag;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_flag_upd && !flags_ctl && i_alu.size == cpu_core_pkg::SIZE_LONG) |=>
            (o_condition_flags[`FLG_N] == $past(i_alu.r[`MSB_LONG]));
    endproperty
    a_neg_flag: assert property (p_neg_flag)
        else $error("negative flag differs from sign bit");

    property p_zero_flag;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_flag_upd && !flags_ctl && i_alu.size == cpu_core_pkg::SIZE_LONG) |=>
            (o_condition_flags[`FLG_Z] == ($past(i_alu.r) == 32'h00000000));
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag wrong");

    property p_half_byte;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_flag_upd && !flags_ctl && i_alu.op == cpu_core_pkg::OP_ADD
            && i_alu.size == cpu_core_pkg::SIZE_BYTE) |=>
            (o_condition_flags[`FLG_H] == $past(i_alu.a[4] ^ i_alu.b[4] ^ i_alu.r[4]));
    endproperty
    a_half_byte: assert property (p_half_byte)
        else $error("half carry not taken from bit three");

    property p_flags_xor;
        @(posedge i_clk) disable iff (!i_resetn)
        (flags_ctl && i_ctl_op == cpu_core_pkg::CTL_XOR && !i_exception_start) |=>
            (o_condition_flags == ($past(o_condition_flags) ^ $past(i_ctl_wdata[7:0])));
    endproperty
    a_flags_xor: assert property (p_flags_xor)
        else $error("flags xor result wrong");

    property p_branch_eq;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_branch_cond == cpu_core_pkg::COND_EQ) |=>
            (o_branch_taken == $past(o_condition_flags[`FLG_Z]));
    endproperty
    a_branch_eq: assert property (p_branch_eq)
        else $error("equal branch ignores zero flag");

    sequence s_sp_write;
        i_sp_wr ##1 1'b1;
    endsequence
    property p_sp_path;
        @(posedge i_clk) disable iff (!i_resetn)
        s_sp_write |=> (o_stack_pointer == $past(i_sp_wdata, 2));
    endproperty
    a_sp_path: assert property (p_sp_path)
        else $error("stack pointer does not follow implicit write");

endmodule : cpu_register_file_and_flags
`default_nettype wire

// File: src/flag_calc.sv
// flag_calc: arithmetic flags from operands and result of one operation
// assumes: subtract and compare give r = a - b, negate gives r = 0 - b
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"
module flag_calc (
    input wire cpu_core_pkg::alu_s i_alu,
    output logic o_h,
    output logic o_n,
    output logic o_z,
    output logic o_v,
    output logic o_c,
    output logic o_c_load
);
    logic [31:0] a;
    logic is_sub;
    int m;
    int hb;

    // ======================================================================
    // flag equations
    always_comb begin
        a = (i_alu.op == cpu_core_pkg::OP_NEG) ? 32'h00000000 : i_alu.a;
        is_sub = (i_alu.op == cpu_core_pkg::OP_SUB) || (i_alu.op == cpu_core_pkg::OP_NEG);
        case (i_alu.size)
            cpu_core_pkg::SIZE_BYTE: begin
                m = `MSB_BYTE;
                hb = `HC_SRC_BYTE + 1;
                o_z = (i_alu.r[`MSB_BYTE:0] == 8'h00);
            end
            cpu_core_pkg::SIZE_WORD: begin
                m = `MSB_WORD;
                hb = `HC_SRC_WORD + 1;
                o_z = (i_alu.r[`MSB_WORD:0] == 16'h0000);
            end
            default: begin
                m = `MSB_LONG;
                hb = `HC_SRC_LONG + 1;
                o_z = (i_alu.r == 32'h00000000);
            end
        endcase
        o_n = i_alu.r[m];
        o_h = 1'b0;
        o_v = 1'b0;
        o_c = 1'b0;
        o_c_load = 1'b1;
        case (i_alu.op)
            cpu_core_pkg::OP_ADD: begin
                o_h = a[hb] ^ i_alu.b[hb] ^ i_alu.r[hb];
                o_v = (a[m] == i_alu.b[m]) && (i_alu.r[m] != a[m]);
                o_c = (a[m] & i_alu.b[m]) | ((a[m] | i_alu.b[m]) & ~i_alu.r[m]);
            end
            cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_NEG: begin
                o_h = a[hb] ^ i_alu.b[hb] ^ i_alu.r[hb];
                o_v = (a[m] != i_alu.b[m]) && (i_alu.r[m] != a[m]);
                o_c = (~a[m] & i_alu.b[m]) | ((~a[m] | i_alu.b[m]) & i_alu.r[m]);
            end
            cpu_core_pkg::OP_SHIFT: begin
                o_c = i_alu.shift_c;
            end
            default: begin
                o_c_load = 1'b0;
            end
        endcase
        if (!is_sub && i_alu.op != cpu_core_pkg::OP_ADD) begin
            o_h = 1'b0;
        end
    end
endmodule : flag_calc
`default_nettype wire

// File: src/gpr_slot.sv
// gpr_slot: one general register with per-lane writes, no reset
// assumes: lane enables and placed data come from the register set
`timescale 1ns/100ps
`default_nettype none
module gpr_slot #(
    parameter int WIDTH = 32,
    parameter int LANES = 4
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic [LANES-1:0] i_lane_en,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_q
);
    localparam int LW = WIDTH / LANES;
    logic [WIDTH-1:0] next_q;

    // ======================================================================
    // lane merge
    always_comb begin
        next_q = o_q;
        for (int l = 0; l < LANES; l++) begin
            if (i_wr_en && i_lane_en[l]) begin
                next_q[l*LW +: LW] = i_wdata[l*LW +: LW];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        o_q <= next_q;
    end

    property p_lane_keep;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr_en && !i_lane_en[LANES-1]) |=>
            (o_q[WIDTH-1 -: LW] == $past(o_q[WIDTH-1 -: LW]));
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("untouched lane changed on partial write");
endmodule : gpr_slot
`default_nettype wire

// File: verif/cpu_register_file_and_flags_test.sv
// cpu_register_file_and_flags_test: directed bench for the cpu register set
// assumes: package and design sources compiled first, one 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module cpu_register_file_and_flags_test;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_gpr_wr = 1'b0, i_sp_wr = 1'b0, i_pc_load = 1'b0;
    logic i_pc_advance = 1'b0, i_flag_upd = 1'b0, i_bit_c_wr = 1'b0, i_bit_c_value = 1'b0;
    logic i_exception_start = 1'b0;
    logic [2:0] i_idx_reg = 3'h3;
    logic [3:0] i_instr_words = 4'h0;
    logic [31:0] i_gpr_wdata = 32'h0, i_sp_wdata = 32'h0, i_pc_value = 32'h0, i_ctl_wdata = 32'h0;
    cpu_core_pkg::gpr_sel_s i_gpr_wr_sel, i_gpr_rd_sel;
    cpu_core_pkg::size_e i_idx_size = cpu_core_pkg::SIZE_BYTE;
    cpu_core_pkg::alu_s i_alu;
    cpu_core_pkg::ctl_op_e i_ctl_op = cpu_core_pkg::CTL_NONE;
    cpu_core_pkg::ctl_tgt_e i_ctl_tgt = cpu_core_pkg::TGT_FLAGS;
    cpu_core_pkg::cond_e i_branch_cond = cpu_core_pkg::COND_EQ;
    logic [31:0] o_gpr_rd_data, o_idx_data, o_stack_pointer, o_pc, o_fetch_addr;
    logic [31:0] o_vector_base, o_short_address_base;
    logic [63:0] o_multiply_accumulator;
    logic [7:0] o_condition_flags, o_extended_control;
    logic o_branch_taken;
    int n_mismatch = 0;
    int samples_checked = 0;
    // ==========================================================================
    // design and clock
    cpu_register_file_and_flags u_cpu_register_file_and_flags (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_gpr_wr(i_gpr_wr), .i_gpr_wr_sel(i_gpr_wr_sel),
        .i_gpr_wdata(i_gpr_wdata), .i_gpr_rd_sel(i_gpr_rd_sel), .i_idx_reg(i_idx_reg),
        .i_idx_size(i_idx_size), .i_sp_wr(i_sp_wr), .i_sp_wdata(i_sp_wdata),
        .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_pc_advance(i_pc_advance),
        .i_instr_words(i_instr_words), .i_flag_upd(i_flag_upd), .i_alu(i_alu),
        .i_bit_c_wr(i_bit_c_wr), .i_bit_c_value(i_bit_c_value), .i_ctl_op(i_ctl_op),
        .i_ctl_tgt(i_ctl_tgt), .i_ctl_wdata(i_ctl_wdata), .i_exception_start(i_exception_start),
        .i_branch_cond(i_branch_cond), .o_gpr_rd_data(o_gpr_rd_data), .o_idx_data(o_idx_data),
        .o_stack_pointer(o_stack_pointer), .o_pc(o_pc), .o_fetch_addr(o_fetch_addr),
        .o_condition_flags(o_condition_flags), .o_extended_control(o_extended_control),
        .o_vector_base(o_vector_base), .o_short_address_base(o_short_address_base),
        .o_multiply_accumulator(o_multiply_accumulator), .o_branch_taken(o_branch_taken));
    always #4 i_clk = ~i_clk;
    // ==========================================================================
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task automatic flag_op(input cpu_core_pkg::size_e sz, input logic [31:0] a, b, r,
                           input logic [7:0] exp,
                           input cpu_core_pkg::op_e op = cpu_core_pkg::OP_ADD);
        cyc(1);
        i_flag_upd <= 1'b1;
        i_alu <= '{op, sz, a, b, r, 1'b0};
        cyc(1);
        i_flag_upd <= 1'b0;
        #1 `CHK(o_condition_flags, exp)
    endtask : flag_op
    task automatic ctl(input cpu_core_pkg::ctl_op_e op, input logic [7:0] d, exp);
        cyc(1);
        i_ctl_op <= op;
        i_ctl_wdata <= {24'h0, d};
        cyc(1);
        i_ctl_op <= cpu_core_pkg::CTL_NONE;
        #1 `CHK(o_condition_flags, exp)
    endtask : ctl
    task automatic t_views;
        cyc(1);
        i_gpr_wr <= 1'b1;
        i_gpr_wdata <= 32'h12345678;
        cyc(1);
        i_gpr_wr_sel.view <= cpu_core_pkg::VIEW_LOW_BYTE;
        i_gpr_wdata <= 32'hFFFFFFAB;
        cyc(1);
        i_gpr_wr_sel.view <= cpu_core_pkg::VIEW_HIGH_BYTE;
        i_gpr_wdata <= 32'h000000CD;
        cyc(1);
        i_gpr_wr_sel.view <= cpu_core_pkg::VIEW_EXT;
        i_gpr_wdata <= 32'h0000BEEF;
        cyc(1);
        i_gpr_wr <= 1'b0;
        cyc(2);
        #1 `CHK(o_gpr_rd_data, 32'hBEEFCDAB)
        `CHK(o_idx_data, 32'h000000AB)
        $display("views done");
    endtask : t_views
    task automatic t_sp_pc;
        cyc(1);
        i_sp_wr <= 1'b1;
        i_sp_wdata <= 32'h0000FFF0;
        i_gpr_wr <= 1'b1;
        i_gpr_wr_sel <= {3'h7, cpu_core_pkg::VIEW_FULL};
        i_pc_load <= 1'b1;
        i_pc_value <= 32'h00001001;
        i_pc_advance <= 1'b1;
        i_instr_words <= 4'h2;
        cyc(1);
        i_sp_wr <= 1'b0;
        i_gpr_wr <= 1'b0;
        i_pc_load <= 1'b0;
        #1 `CHK(o_fetch_addr, 32'h00001000)
        cyc(1);
        i_pc_advance <= 1'b0;
        #1 `CHK(o_pc, 32'h00001005)
        cyc(2);
        #1 `CHK(o_stack_pointer, 32'h0000FFF0)
        $display("stack and counter done");
    endtask : t_sp_pc
    task automatic t_flags;
        flag_op(cpu_core_pkg::SIZE_BYTE, 32'h0F, 32'h01, 32'h10, 8'hA0);
        flag_op(cpu_core_pkg::SIZE_WORD, 32'h0FFF, 32'h01, 32'h1000, 8'hA0);
        flag_op(cpu_core_pkg::SIZE_BYTE, 32'h7F, 32'h01, 32'h80, 8'hAA);
        flag_op(cpu_core_pkg::SIZE_BYTE, 32'hFF, 32'h01, 32'h00, 8'hA5);
        cyc(2);
        #1 `CHK(o_branch_taken, 1'b1)
        cyc(1);
        i_branch_cond <= cpu_core_pkg::COND_NE;
        cyc(2);
        #1 `CHK(o_branch_taken, 1'b0)
        ctl(cpu_core_pkg::CTL_LOAD, 8'h50, 8'h50);
        ctl(cpu_core_pkg::CTL_XOR, 8'h10, 8'h40);
        ctl(cpu_core_pkg::CTL_OR, 8'h0F, 8'h4F);
        ctl(cpu_core_pkg::CTL_AND, 8'h41, 8'h41);
        cyc(1);
        i_exception_start <= 1'b1;
        cyc(1);
        i_exception_start <= 1'b0;
        i_bit_c_wr <= 1'b1;
        #1 `CHK(o_condition_flags, 8'hC1)
        cyc(1);
        i_bit_c_wr <= 1'b0;
        #1 `CHK(o_condition_flags, 8'hC0)
        flag_op(cpu_core_pkg::SIZE_BYTE, 32'h0F, 32'h01, 32'h10, 8'hE0);
        flag_op(cpu_core_pkg::SIZE_LONG, 32'h7FFFFFFF, 32'h1, 32'h80000000, 8'hEA);
        flag_op(cpu_core_pkg::SIZE_BYTE, 32'h0, 32'h1, 32'hFF, 8'hE9,
                cpu_core_pkg::OP_SUB);
        $display("flags done");
    endtask : t_flags
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    // ==========================================================================
    // main sequence and watchdog
    initial begin
        i_gpr_wr_sel = {3'h3, cpu_core_pkg::VIEW_FULL};
        i_gpr_rd_sel = {3'h3, cpu_core_pkg::VIEW_FULL};
        i_alu = '{cpu_core_pkg::OP_ADD, cpu_core_pkg::SIZE_BYTE, 32'h0, 32'h0, 32'h0, 1'b0};
        cyc(10);
        i_resetn <= 1'b1;
        #1 `CHK(o_condition_flags, 8'h80)
        `CHK(o_extended_control, 8'h7F)
        `CHK(o_short_address_base, 32'hFFFFFF00)
        `CHK(o_vector_base, 32'h0)
        `CHK(o_multiply_accumulator, 64'h0)
        $display("reset done");
        t_views();
        t_sp_pc();
        t_flags();
        end_sim();
    end
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
endmodule : cpu_register_file_and_flags_test
`default_nettype wire
